// ===== dv/spi_fault_burst_reset_regs_bench.sv
`timescale 1ns/1ps
module spi_fault_burst_reset_regs_bench;
  localparam logic [7:0] F_RW = 8'(1 << spi_fault_burst_pkg::FLAG_RW_BIT);
  localparam logic [7:0] F_SCLK = 8'(1 << spi_fault_burst_pkg::FLAG_SCLK_BIT);
  localparam logic [7:0] F_CRC = 8'(1 << spi_fault_burst_pkg::FLAG_CRC_BIT);
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b0;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic [7:0] switch_en;
  logic crc_on = 1'b0;
  logic [7:0] rnd = 8'h30;
  logic [7:0] rdat;
  logic [47:0] rx;
  logic [6:0] bad_rd [3] = '{7'h00, 7'h04, 7'h7F};
  logic [6:0] bad_wr [3] = '{7'h03, 7'h04, 7'h7F};
  int num_errors = 0;
  int checks = 0;

  // ----------------------------------------
  // Clock, design and host
  // ----------------------------------------
  always #2.5 clk_sys_i = ~clk_sys_i;

  spi_fault_burst_reset_regs dut_u (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .sclk_i(sclk),
    .cs_n_i(cs_n),
    .mosi_i(mosi),
    .miso_o(miso),
    .switch_en_o(switch_en)
  );

  spi_host_model host_u (
    .sclk_o(sclk),
    .cs_n_o(cs_n),
    .mosi_o(mosi),
    .miso_i(miso)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Bitwise checksum, worked out independently of the design
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = spi_fault_burst_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ((c << 1) ^ spi_fault_burst_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Gap of 40 cycles lets writes land and keeps select high long enough
  task automatic frame(input logic [47:0] v, input int n);
    host_u.xfer(v, n, rx);
    repeat (40) @(posedge clk_sys_i);
  endtask

  task automatic cmd(input logic [15:0] w, input logic bad);
    logic [7:0] c;
    c = crc8(w) ^ {7'h00, bad};
    if (crc_on) begin
      frame({w, c, 24'h000000}, 24);
    end else begin
      frame({w, 32'h00000000}, 16);
    end
    rdat = rx[39:32];
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    cmd({1'b0, a, d}, 1'b0);
  endtask

  task automatic rd(input logic [6:0] a);
    cmd({1'b1, a, 8'h00}, 1'b0);
  endtask

  task automatic two(input logic [15:0] w1, input logic [15:0] w2);
    if (crc_on) begin
      frame({w1, crc8(w1), w2, crc8(w2)}, 48);
    end else begin
      frame({w1, w2, 16'h0000}, 32);
    end
  endtask

  task automatic chk_reg(input logic [6:0] a, input logic [7:0] exp);
    rd(a);
    chk8(rdat, exp, "register read");
  endtask

  task automatic clear_flags();
    cmd(spi_fault_burst_pkg::CLEAR_CMD, 1'b0);
  endtask

  task automatic summarize();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    // A real rising edge is needed, or the link-side flops never leave unknown
    reset_i <= 1'b1;
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    chk8(switch_en, 8'h00, "switch after reset");
    chk_reg(spi_fault_burst_pkg::ADDR_FAULT, 8'h00);
    chk_reg(spi_fault_burst_pkg::ADDR_MULTI, 8'h00);
    chk_reg(spi_fault_burst_pkg::ADDR_RESTART, 8'h00);
    // Non-key value written to the restart register must still read zero
    wr(spi_fault_burst_pkg::ADDR_RESTART, 8'h5A);
    chk_reg(spi_fault_burst_pkg::ADDR_RESTART, 8'h00);
    // Random switch patterns, read back over the link
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr_next(rnd);
      wr(spi_fault_burst_pkg::ADDR_SWITCH, rnd);
      chk8(switch_en, rnd, "switch output");
      chk_reg(spi_fault_burst_pkg::ADDR_SWITCH, rnd);
    end
    // Missing read targets; flag must survive a good frame
    for (int i = 0; i < 3; i++) begin
      rd(bad_rd[i]);
      rd(spi_fault_burst_pkg::ADDR_SWITCH);
      chk_reg(spi_fault_burst_pkg::ADDR_FAULT, F_RW);
      clear_flags();
      chk_reg(spi_fault_burst_pkg::ADDR_FAULT, 8'h00);
    end
    // Missing or read-only write targets leave the switch alone
    for (int i = 0; i < 3; i++) begin
      wr(bad_wr[i], 8'h00);
      chk8(switch_en, rnd, "switch after bad write");
      chk_reg(spi_fault_burst_pkg::ADDR_FAULT, F_RW);
      clear_flags();
    end
    // Short and long frames
    frame({1'b1, spi_fault_burst_pkg::ADDR_SWITCH, 40'h0}, 15);
    chk_reg(spi_fault_burst_pkg::ADDR_FAULT, F_SCLK);
    clear_flags();
    frame({1'b1, spi_fault_burst_pkg::ADDR_SWITCH, 40'h0}, 17);
    chk_reg(spi_fault_burst_pkg::ADDR_FAULT, F_SCLK);
    clear_flags();
    // Two words without burst: second ignored, count fault
    two({1'b0, spi_fault_burst_pkg::ADDR_SWITCH, 8'h11}, {1'b0, spi_fault_burst_pkg::ADDR_SWITCH, 8'h22});
    chk8(switch_en, 8'h11, "switch no burst");
    chk_reg(spi_fault_burst_pkg::ADDR_FAULT, F_SCLK);
    clear_flags();
    // Burst on: both words decoded, no count fault
    wr(spi_fault_burst_pkg::ADDR_MULTI, 8'h01);
    chk_reg(spi_fault_burst_pkg::ADDR_MULTI, 8'h01);
    two({1'b0, spi_fault_burst_pkg::ADDR_SWITCH, 8'h33}, {1'b0, spi_fault_burst_pkg::ADDR_SWITCH, 8'h44});
    chk8(switch_en, 8'h44, "switch burst");
    chk_reg(spi_fault_burst_pkg::ADDR_FAULT, 8'h00);
    // Key broken by another command does nothing
    wr(spi_fault_burst_pkg::ADDR_RESTART, spi_fault_burst_pkg::KEY_FIRST);
    wr(spi_fault_burst_pkg::ADDR_SWITCH, 8'h55);
    wr(spi_fault_burst_pkg::ADDR_RESTART, spi_fault_burst_pkg::KEY_SECOND);
    chk8(switch_en, 8'h55, "switch after broken key");
    chk_reg(spi_fault_burst_pkg::ADDR_MULTI, 8'h01);
    // Full key restores defaults
    wr(spi_fault_burst_pkg::ADDR_ERR_CFG, 8'h04);
    wr(spi_fault_burst_pkg::ADDR_RESTART, spi_fault_burst_pkg::KEY_FIRST);
    wr(spi_fault_burst_pkg::ADDR_RESTART, spi_fault_burst_pkg::KEY_SECOND);
    chk8(switch_en, 8'h00, "switch after key");
    chk_reg(spi_fault_burst_pkg::ADDR_MULTI, 8'h00);
    chk_reg(spi_fault_burst_pkg::ADDR_ERR_CFG, 8'h06);
    // Checksum framing
    wr(spi_fault_burst_pkg::ADDR_ERR_CFG, 8'h07);
    crc_on = 1'b1;
    wr(spi_fault_burst_pkg::ADDR_SWITCH, 8'h66);
    chk8(switch_en, 8'h66, "switch checked write");
    chk_reg(spi_fault_burst_pkg::ADDR_FAULT, 8'h00);
    cmd({1'b0, spi_fault_burst_pkg::ADDR_SWITCH, 8'h77}, 1'b1);
    chk8(switch_en, 8'h66, "switch bad checksum");
    chk_reg(spi_fault_burst_pkg::ADDR_FAULT, F_CRC);
    cmd(spi_fault_burst_pkg::CLEAR_CMD, 1'b1);
    chk_reg(spi_fault_burst_pkg::ADDR_FAULT, F_CRC);
    clear_flags();
    chk_reg(spi_fault_burst_pkg::ADDR_FAULT, 8'h00);
    wr(spi_fault_burst_pkg::ADDR_MULTI, 8'h01);
    two({1'b0, spi_fault_burst_pkg::ADDR_SWITCH, 8'h12}, {1'b0, spi_fault_burst_pkg::ADDR_SWITCH, 8'h34});
    chk8(switch_en, 8'h34, "switch checked burst");
    chk_reg(spi_fault_burst_pkg::ADDR_FAULT, 8'h00);
    frame({1'b1, spi_fault_burst_pkg::ADDR_SWITCH, 40'h0}, 16);
    chk_reg(spi_fault_burst_pkg::ADDR_FAULT, F_SCLK);
    // Hardware reset in mid-run clears flags and restores config to its default 6
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    crc_on = 1'b0;
    repeat (10) @(posedge clk_sys_i);
    chk8(switch_en, 8'h00, "switch after second reset");
    chk_reg(spi_fault_burst_pkg::ADDR_FAULT, 8'h00);
    chk_reg(spi_fault_burst_pkg::ADDR_ERR_CFG, 8'h06);
    summarize();
  end

  // Run needs roughly 104 us; cut off well past that
  initial begin
    #400000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
endmodule

// ===== dv/spi_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Mode 0 serial host, clock still between frames
// ----------------------------------------
module spi_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Sends n bits of v from the top, MSB first; 64 ns serial period
  task automatic xfer(input logic [47:0] v, input int n, output logic [47:0] r);
    r = '0;
    cs_n_o = 1'b0;
    #13.7;
    for (int i = 0; i < n; i++) begin
      mosi_o = v[47 - i];
      #32;
      sclk_o = 1'b1;
      r[47 - i] = miso_i;
      #32;
      sclk_o = 1'b0;
    end
    #13.7;
    cs_n_o = 1'b1;
    // Released line shows the inverse so a stale level is never trusted
    mosi_o = ~mosi_o;
  endtask
endmodule

// ===== hdl/spi_fault_burst_pkg.sv
package spi_fault_burst_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_SWITCH = 7'h01;
  localparam logic [6:0] ADDR_ERR_CFG = 7'h02;
  localparam logic [6:0] ADDR_FAULT = 7'h03;
  localparam logic [6:0] ADDR_MULTI = 7'h05;
  localparam logic [6:0] ADDR_RESTART = 7'h0B;
  localparam logic [7:0] SWITCH_RST = 8'h00;
  localparam logic [2:0] ERR_CFG_RST = 3'h6;
  localparam logic [2:0] FAULT_RST = 3'h0;
  localparam logic MULTI_RST = 1'h0;
  localparam logic [7:0] RESTART_READ = 8'h00;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CFG_RW_BIT = 2;
  localparam int CFG_SCLK_BIT = 1;
  localparam int CFG_CRC_BIT = 0;
  localparam int FLAG_RW_BIT = 2;
  localparam int FLAG_SCLK_BIT = 1;
  localparam int FLAG_CRC_BIT = 0;
  localparam int CMD_READ_BIT = 15;
  // Image of readable state handed to the link side
  localparam int IMG_W = 15;
  localparam int IMG_CFG_LSB = 8;
  localparam int IMG_FLAG_LSB = 11;
  localparam int IMG_MULTI_BIT = 14;
  // ------------------------------------------------------------
  // Commands and framing
  // ------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'hA3;
  localparam logic [7:0] KEY_SECOND = 8'h05;
  localparam logic [15:0] CLEAR_CMD = 16'h6CA9;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] FRAME_BITS_CRC = 5'h18;
  localparam logic [4:0] ADDR_DONE_POS = 5'h07;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
endpackage

// ===== hdl/spi_fault_burst_reset_regs.sv
`timescale 1ns/1ps
module spi_fault_burst_reset_regs (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic [7:0] switch_en_o
);
  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic rd_ok(input logic [6:0] a);
    rd_ok = (a == spi_fault_burst_pkg::ADDR_SWITCH) || (a == spi_fault_burst_pkg::ADDR_ERR_CFG) ||
      (a == spi_fault_burst_pkg::ADDR_FAULT) || (a == spi_fault_burst_pkg::ADDR_MULTI) ||
      (a == spi_fault_burst_pkg::ADDR_RESTART);
  endfunction

  // Fault register is read-only, so it is missing from the write set
  function automatic logic wr_ok(input logic [6:0] a);
    wr_ok = rd_ok(a) && (a != spi_fault_burst_pkg::ADDR_FAULT);
  endfunction

  function automatic logic [7:0] read_mux(input logic [14:0] img, input logic [6:0] a);
    read_mux = 8'h00;
    case (a)
      spi_fault_burst_pkg::ADDR_SWITCH: read_mux = img[7:0];
      spi_fault_burst_pkg::ADDR_ERR_CFG: read_mux = {5'h00, img[10:8]};
      spi_fault_burst_pkg::ADDR_FAULT: read_mux = {5'h00, img[13:11]};
      spi_fault_burst_pkg::ADDR_MULTI: read_mux = {7'h00, img[14]};
      spi_fault_burst_pkg::ADDR_RESTART: read_mux = spi_fault_burst_pkg::RESTART_READ;
      default: read_mux = 8'h00;
    endcase
  endfunction

  // Bitwise CRC-8, MSB first over the two command bytes
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = spi_fault_burst_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ w[i]) begin
        c = {c[6:0], 1'b0} ^ spi_fault_burst_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc8 = c;
  endfunction

  // ------------------------------------------------------------
  // Link side, clocked by the serial clock
  // ------------------------------------------------------------
  logic in_frame;
  logic frame_clr;
  logic [4:0] bit_pos, next_bit_pos;
  logic [23:0] shreg, next_shreg;
  logic [23:0] word, next_word;
  logic word_tgl, next_word_tgl;
  logic [7:0] tx, next_tx;
  logic [2:0] lreq_s, next_lreq_s;
  logic img_ack, next_img_ack;
  logic [14:0] img_link, next_img_link;
  logic [14:0] img_hold;
  logic img_req;
  logic [4:0] pos0;
  logic [4:0] frame_len;

  // Select high ends the frame at once; the clock may never tick again
  assign frame_clr = cs_n_i | reset_i;

  always_ff @(posedge sclk_i or posedge frame_clr) begin
    if (frame_clr) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  // Bit counting, word capture, read data load and image pickup
  always_comb begin
    frame_len = img_link[spi_fault_burst_pkg::CFG_CRC_BIT + spi_fault_burst_pkg::IMG_CFG_LSB] ?
      spi_fault_burst_pkg::FRAME_BITS_CRC : spi_fault_burst_pkg::FRAME_BITS;
    pos0 = in_frame ? bit_pos : 5'h00;
    next_shreg = {shreg[22:0], mosi_i};
    next_bit_pos = 5'(pos0 + 5'h01);
    next_word = word;
    next_word_tgl = word_tgl;
    if (next_bit_pos == frame_len) begin
      next_bit_pos = 5'h00;
      next_word = next_shreg;
      next_word_tgl = ~word_tgl;
    end
    if (pos0 == spi_fault_burst_pkg::ADDR_DONE_POS) begin
      next_tx = read_mux(img_link, {shreg[5:0], mosi_i});
    end else begin
      next_tx = {tx[6:0], 1'b0};
    end
    next_lreq_s = {lreq_s[1:0], img_req};
    next_img_ack = img_ack;
    next_img_link = img_link;
    // Image is only taken once both late stages agree on a new toggle
    if ((lreq_s[1] == lreq_s[2]) && (lreq_s[2] != img_ack)) begin
      next_img_link = img_hold;
      next_img_ack = lreq_s[2];
    end
  end

  always_ff @(posedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_pos <= 5'h00;
      shreg <= 24'h000000;
      word <= 24'h000000;
      word_tgl <= 1'b0;
      tx <= 8'h00;
      lreq_s <= 3'h0;
      img_ack <= 1'b0;
      img_link <= {spi_fault_burst_pkg::MULTI_RST, spi_fault_burst_pkg::FAULT_RST,
        spi_fault_burst_pkg::ERR_CFG_RST, spi_fault_burst_pkg::SWITCH_RST};
    end else begin
      bit_pos <= next_bit_pos;
      shreg <= next_shreg;
      word <= next_word;
      word_tgl <= next_word_tgl;
      tx <= next_tx;
      lreq_s <= next_lreq_s;
      img_ack <= next_img_ack;
      img_link <= next_img_link;
    end
  end

  // Read data shifts out on the falling edge for the host's rising sample
  always_ff @(negedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      miso_o <= 1'b0;
    end else begin
      miso_o <= tx[7];
    end
  end

  // ------------------------------------------------------------
  // System side synchronisers
  // ------------------------------------------------------------
  // Index 0 select, 1 word toggle, 2 image acknowledge
  logic [2:0] sync_in;
  logic [2:0] s1, s2, s3, sq;
  logic [2:0] next_s1, next_s2, next_s3, next_sq;
  logic [2:0] agree_new;

  assign sync_in = {img_ack, word_tgl, cs_n_i};

  always_comb begin
    next_s1 = sync_in;
    next_s2 = s1;
    next_s3 = s2;
    next_sq = sq;
    for (int i = 0; i < 3; i++) begin
      agree_new[i] = (s2[i] == s3[i]) && (s3[i] != sq[i]);
      if (s2[i] == s3[i]) begin
        next_sq[i] = s3[i];
      end
    end
  end

  // ------------------------------------------------------------
  // Register file and command decode
  // ------------------------------------------------------------
  logic [7:0] sw, next_sw;
  logic [2:0] cfg, next_cfg;
  logic [2:0] flags, next_flags;
  logic burst, next_burst;
  logic armed, next_armed;
  logic [1:0] words, next_words;
  logic [14:0] next_img_hold;
  logic next_img_req;
  logic [14:0] live_img;
  logic frame_end, word_evt, dec_go, crc_ok, cmd_clear, soft_rst, sclk_bad;
  logic [15:0] cmd;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_data;

  assign frame_end = agree_new[0] && s3[0];
  assign word_evt = agree_new[1];
  assign live_img = {burst, flags, cfg, sw};
  assign cmd = cfg[spi_fault_burst_pkg::CFG_CRC_BIT] ? word[23:8] : word[15:0];
  assign cmd_addr = cmd[14:8];
  assign cmd_data = cmd[7:0];
  // Checksum is only checked while checksum protection is on
  assign crc_ok = !cfg[spi_fault_burst_pkg::CFG_CRC_BIT] || (crc8(cmd) == word[7:0]);

  always_comb begin
    next_sw = sw;
    next_cfg = cfg;
    next_flags = flags;
    next_burst = burst;
    next_armed = armed;
    next_words = words;
    cmd_clear = 1'b0;
    soft_rst = 1'b0;
    sclk_bad = 1'b0;
    // Without multi-command only the first word of a frame is obeyed
    dec_go = word_evt && (burst || (words == 2'h0));
    if (word_evt && (words != 2'h3)) begin
      next_words = 2'(words + 2'h1);
    end
    if (dec_go) begin
      next_armed = 1'b0;
      if (!crc_ok) begin
        if (!cmd[spi_fault_burst_pkg::CMD_READ_BIT]) begin
          next_flags[spi_fault_burst_pkg::FLAG_CRC_BIT] = 1'b1;
        end
      end else if (cmd == spi_fault_burst_pkg::CLEAR_CMD) begin
        next_flags = 3'h0;
        cmd_clear = 1'b1;
      end else if (cmd[spi_fault_burst_pkg::CMD_READ_BIT]) begin
        if (!rd_ok(cmd_addr) && cfg[spi_fault_burst_pkg::CFG_RW_BIT]) begin
          next_flags[spi_fault_burst_pkg::FLAG_RW_BIT] = 1'b1;
        end
      end else if (!wr_ok(cmd_addr)) begin
        if (cfg[spi_fault_burst_pkg::CFG_RW_BIT]) begin
          next_flags[spi_fault_burst_pkg::FLAG_RW_BIT] = 1'b1;
        end
      end else begin
        case (cmd_addr)
          spi_fault_burst_pkg::ADDR_SWITCH: next_sw = cmd_data;
          spi_fault_burst_pkg::ADDR_ERR_CFG: next_cfg = cmd_data[2:0];
          // Upper bits are expected zero and are not stored
          spi_fault_burst_pkg::ADDR_MULTI: next_burst = cmd_data[0];
          spi_fault_burst_pkg::ADDR_RESTART: begin
            if (armed && (cmd_data == spi_fault_burst_pkg::KEY_SECOND)) begin
              soft_rst = 1'b1;
            end else begin
              next_armed = (cmd_data == spi_fault_burst_pkg::KEY_FIRST);
            end
          end
          default: next_armed = 1'b0;
        endcase
      end
    end
    if (soft_rst) begin
      next_sw = spi_fault_burst_pkg::SWITCH_RST;
      next_cfg = spi_fault_burst_pkg::ERR_CFG_RST;
      next_flags = spi_fault_burst_pkg::FAULT_RST;
      next_burst = spi_fault_burst_pkg::MULTI_RST;
      next_armed = 1'b0;
    end
    // Link counter is still since the clock stopped with the select
    if (frame_end) begin
      sclk_bad = (next_words == 2'h0) || (bit_pos != 5'h00) ||
        (!burst && (next_words > 2'h1));
      if (sclk_bad && cfg[spi_fault_burst_pkg::CFG_SCLK_BIT]) begin
        next_flags[spi_fault_burst_pkg::FLAG_SCLK_BIT] = 1'b1;
      end
      next_words = 2'h0;
    end
    // A new image waits until the previous one is acknowledged
    next_img_hold = img_hold;
    next_img_req = img_req;
    if ((s3[2] == img_req) && (sq[2] == img_req) && (img_hold != live_img)) begin
      next_img_hold = live_img;
      next_img_req = ~img_req;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s1 <= 3'h1;
      s2 <= 3'h1;
      s3 <= 3'h1;
      sq <= 3'h1;
      sw <= spi_fault_burst_pkg::SWITCH_RST;
      cfg <= spi_fault_burst_pkg::ERR_CFG_RST;
      flags <= spi_fault_burst_pkg::FAULT_RST;
      burst <= spi_fault_burst_pkg::MULTI_RST;
      armed <= 1'b0;
      words <= 2'h0;
      img_hold <= {spi_fault_burst_pkg::MULTI_RST, spi_fault_burst_pkg::FAULT_RST,
        spi_fault_burst_pkg::ERR_CFG_RST, spi_fault_burst_pkg::SWITCH_RST};
      img_req <= 1'b0;
      switch_en_o <= spi_fault_burst_pkg::SWITCH_RST;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
      sq <= next_sq;
      sw <= next_sw;
      cfg <= next_cfg;
      flags <= next_flags;
      burst <= next_burst;
      armed <= next_armed;
      words <= next_words;
      img_hold <= next_img_hold;
      img_req <= next_img_req;
      switch_en_o <= next_sw;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic rst_q;
  always_ff @(posedge clk_sys_i) begin
    rst_q <= reset_i;
  end

  property p_rd_bad;
    @(posedge clk_sys_i) disable iff (reset_i)
      dec_go && crc_ok && cmd[15] && !rd_ok(cmd_addr) && cfg[2] |=> flags[2];
  endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("bad read address not flagged");

  property p_wr_bad;
    @(posedge clk_sys_i) disable iff (reset_i)
      dec_go && crc_ok && !cmd[15] && (cmd != 16'h6CA9) && (cmd_addr == 7'h03) && cfg[2]
      |=> flags[2];
  endproperty
  a_wr_bad: assert property (p_wr_bad) else $error("read-only write not flagged");

  property p_sclk;
    @(posedge clk_sys_i) disable iff (reset_i)
      frame_end && cfg[1] && (bit_pos != 5'h00) |=> flags[1];
  endproperty
  a_sclk: assert property (p_sclk) else $error("clock-count fault missed");

  property p_crc;
    @(posedge clk_sys_i) disable iff (reset_i)
      dec_go && cfg[0] && (crc8(cmd) != word[7:0]) && !cmd[15] |=> flags[0] && $stable(sw);
  endproperty
  a_crc: assert property (p_crc) else $error("checksum fault missed");

  // Watches the shifter load itself, not the decode function
  property p_upper_zero;
    @(posedge sclk_i) disable iff (reset_i)
      (pos0 == spi_fault_burst_pkg::ADDR_DONE_POS) &&
      ({shreg[5:0], mosi_i} == spi_fault_burst_pkg::ADDR_FAULT) |=> (tx[7:3] == 5'h00);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("fault bits 7..3 not zero");

  // A later word of a burst frame must really reach the switch register
  property p_burst_go;
    @(posedge clk_sys_i) disable iff (reset_i)
      word_evt && burst && (words != 2'h0) && crc_ok && !cmd[15] &&
      (cmd_addr == spi_fault_burst_pkg::ADDR_SWITCH) |=> (sw == $past(cmd_data));
  endproperty
  a_burst_go: assert property (p_burst_go) else $error("burst word not decoded");

  property p_reset_vals;
    @(posedge clk_sys_i) disable iff (reset_i)
      rst_q |-> (burst == 1'b0) && (flags == 3'h0) && (cfg == 3'h6);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  property p_key;
    @(posedge clk_sys_i) disable iff (reset_i)
      soft_rst |=> (sw == 8'h00) && !burst && (flags == 3'h0) && (cfg == 3'h6) ##1 !armed;
  endproperty
  a_key: assert property (p_key) else $error("restart key did not restore defaults");

  property p_restart_read;
    @(posedge sclk_i) disable iff (reset_i)
      (pos0 == spi_fault_burst_pkg::ADDR_DONE_POS) &&
      ({shreg[5:0], mosi_i} == spi_fault_burst_pkg::ADDR_RESTART) |=> (tx == 8'h00);
  endproperty
  a_restart_read: assert property (p_restart_read) else $error("restart reg not zero");

  property p_clear;
    @(posedge clk_sys_i) disable iff (reset_i)
      dec_go && crc_ok && (cmd == spi_fault_burst_pkg::CLEAR_CMD) && !frame_end
      |=> (flags == 3'h0);
  endproperty
  a_clear: assert property (p_clear) else $error("clear command left faults");

  property p_sticky;
    @(posedge clk_sys_i) disable iff (reset_i)
      !cmd_clear && !soft_rst |=> (flags & $past(flags)) == $past(flags);
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault dropped without clear");

  c_clear: cover property (@(posedge clk_sys_i) disable iff (reset_i) cmd_clear);
  c_soft: cover property (@(posedge clk_sys_i) disable iff (reset_i) soft_rst);
  c_burst: cover property (@(posedge clk_sys_i) disable iff (reset_i)
    frame_end && burst && (next_words == 2'h2));
  c_sclk: cover property (@(posedge clk_sys_i) disable iff (reset_i) frame_end && sclk_bad);
endmodule
